//--- bench/elc_error_logging_chk.sv
// Checker for the error logger, watching only its top-level ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module elc_error_logging_chk import elc_pkg::*; #(
	parameter int PKT_W = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic csr_valid,
	input wire logic csr_ready,
	input wire logic xb_rsp_valid,
	input wire logic [3:0] xb_rsp_src,
	input wire logic xb_rsp_to_io,
	input wire logic xb_rsp_no_dummy,
	input wire logic msg_err_valid,
	input wire logic [7:0] msg_err_code,
	input wire logic pkt_in_valid,
	input wire logic [PKT_W-1:0] pkt_in_data,
	input wire logic pkt_in_par,
	input wire logic pkt_out_valid,
	input wire logic [PKT_W-1:0] pkt_out_data,
	input wire logic pkt_out_par,
	input wire logic mem_rd_valid,
	input wire logic mem_sbe,
	input wire logic mem_mbe,
	input wire logic mem_is_tag,
	input wire logic mem_rsp_valid,
	input wire logic mem_sbe_intr,
	input wire logic mem_hard_err,
	input wire logic proc_directed_err,
	input wire logic proc_dummy_rsp,
	input wire logic high_priority_machine_check,
	input wire logic io_err_valid,
	input wire logic [CSR_DW-1:0] io_err_data,
	input wire logic msg_intr,
	input wire logic opq_wr,
	input wire logic [7:0] opq_code
);
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking @(posedge clk); endclocking
default disable iff (rst);
sequence s_to_cpu;
	xb_rsp_valid && !xb_rsp_to_io;
endsequence
sequence s_dir;
	proc_directed_err && high_priority_machine_check;
endsequence
a_csr_answer:
	assert property (csr_valid |=> csr_ready)
	else $error("csr access not answered");
a_ready_cause:
	assert property (csr_ready |-> $past(csr_valid))
	else $error("csr ready without access");
a_directed_err:
	assert property (s_to_cpu |=> s_dir)
	else $error("no directed error for processor");
a_dummy_next:
	assert property (s_to_cpu ##0 !xb_rsp_no_dummy |=> s_dir ##1 proc_dummy_rsp)
	else $error("dummy response missing");
a_io_forward:
	assert property (xb_rsp_valid && xb_rsp_to_io
		|=> io_err_valid && !proc_directed_err)
	else $error("io response not forwarded");
a_io_source:
	assert property (xb_rsp_valid && xb_rsp_to_io
		|=> io_err_data[35:32] == $past(xb_rsp_src))
	else $error("forwarded source code wrong");
a_msg_queue:
	assert property (msg_err_valid
		|=> msg_intr && opq_wr && opq_code == $past(msg_err_code))
	else $error("message error not queued");
a_parity_pass:
	assert property (pkt_in_valid |=> pkt_out_valid
		&& pkt_out_data == $past(pkt_in_data)
		&& pkt_out_par == $past(pkt_in_par))
	else $error("packet parity not passed");
// Interrupt and hard flag pass the report stage, then the output flop
a_sbe_intr:
	assert property (mem_rd_valid && mem_sbe && !mem_mbe |-> ##2 mem_sbe_intr)
	else $error("single-bit interrupt missing");
a_tag_hard:
	assert property (mem_rd_valid && mem_mbe && mem_is_tag
		|=> !mem_rsp_valid ##1 mem_hard_err)
	else $error("tag multibit not hard");
endmodule
bind elc_error_logging elc_error_logging_chk #(.PKT_W(PKT_W)) u_chk (
	.clk, .rst, .csr_valid, .csr_ready, .xb_rsp_valid, .xb_rsp_src,
	.xb_rsp_to_io, .xb_rsp_no_dummy, .msg_err_valid, .msg_err_code,
	.pkt_in_valid, .pkt_in_data, .pkt_in_par, .pkt_out_valid,
	.pkt_out_data, .pkt_out_par, .mem_rd_valid, .mem_sbe, .mem_mbe,
	.mem_is_tag, .mem_rsp_valid, .mem_sbe_intr, .mem_hard_err,
	.proc_directed_err, .proc_dummy_rsp, .high_priority_machine_check,
	.io_err_valid, .io_err_data, .msg_intr, .opq_wr, .opq_code
);
`default_nettype wire

//--- bench/elc_xb_model.sv
// Crossbar side model: delivers error responses to the logger.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module elc_xb_model (
	input wire logic clk,
	output logic xb_rsp_valid,
	output logic [3:0] xb_rsp_src,
	output logic xb_rsp_to_io,
	output logic xb_rsp_no_dummy,
	output logic short_response_packet_flag,
	output logic [5:0] xb_rsp_ttype,
	output logic [5:0] transaction_tag,
	output logic [2:0] xb_rsp_chip,
	output logic [2:0] xb_rsp_board,
	output logic [4:0] xb_rsp_code,
	output logic [31:0] xb_rsp_other
);
initial begin
	xb_rsp_valid = 1'b0;
	{xb_rsp_src, xb_rsp_to_io, xb_rsp_no_dummy} = 6'h00;
	{short_response_packet_flag, xb_rsp_ttype, transaction_tag} = 13'h0000;
	{xb_rsp_chip, xb_rsp_board, xb_rsp_code, xb_rsp_other} = 43'h0;
end
task automatic send(input logic [3:0] s, input logic io, input logic nd,
		input logic [23:0] f, input logic [31:0] o);
	xb_rsp_valid = 1'b1;
	{xb_rsp_src, xb_rsp_to_io, xb_rsp_no_dummy} = {s, io, nd};
	{short_response_packet_flag, xb_rsp_ttype, transaction_tag,
		xb_rsp_chip, xb_rsp_board, xb_rsp_code} = f;
	xb_rsp_other = o;
	@(posedge clk);
	#1;
	// Stale fields flip so nothing can lean on them
	xb_rsp_valid = 1'b0;
	{xb_rsp_src, xb_rsp_to_io, xb_rsp_no_dummy} = ~{s, io, nd};
	{short_response_packet_flag, xb_rsp_ttype, transaction_tag,
		xb_rsp_chip, xb_rsp_board, xb_rsp_code} = ~f;
	xb_rsp_other = ~o;
	repeat (3) @(posedge clk);
	#1;
endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the error logger through its CSR port.
// Assumes the crossbar model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("Error at %0t got %h expected %h", $time, a, e); end end
module testbench import elc_pkg::*;;
logic clk = 1'b0, rst = 1'b1, scan_en = 1'b0, scan_in = 1'b0;
logic csr_valid = 1'b0, csr_write = 1'b0, tmo_valid = 1'b0;
logic msg_err_valid = 1'b0, pkt_in_valid = 1'b0, pkt_in_par = 1'b0;
logic mem_rd_valid = 1'b0, mem_sbe = 1'b0, mem_mbe = 1'b0, mem_is_tag = 1'b0;
logic [7:0] csr_addr = 8'h00, msg_err_code = 8'h00;
logic [63:0] csr_wdata = 64'h0, pkt_in_data = 64'h0, mem_rd_data = 64'h0;
logic [39:0] tmo_addr = 40'h0, mem_rd_addr = 40'h0;
logic [5:0] mem_sbe_bit = 6'h04;
logic [63:0] csr_rdata, pkt_out_data, mem_rsp_data, io_err_data, rdv;
logic csr_ready, scan_out, pkt_out_valid, pkt_out_par, mem_rsp_valid;
logic mem_rsp_par_err, mem_sbe_intr, mem_hard_err, proc_directed_err;
logic proc_dummy_rsp, high_priority_machine_check, io_err_valid, msg_intr;
logic opq_wr, xb_rsp_valid, xb_rsp_to_io, xb_rsp_no_dummy;
logic short_response_packet_flag;
logic [7:0] opq_code, err_ignore;
logic [3:0] xb_rsp_src;
logic [5:0] xb_rsp_ttype, transaction_tag;
logic [2:0] xb_rsp_chip, xb_rsp_board;
logic [4:0] xb_rsp_code;
logic [31:0] xb_rsp_other;
int checked = 0, miscompares = 0, cycles = 0;
localparam logic [23:0] FLD = 24'hAD5B51;
localparam logic [39:0] TADR = 40'h12_3456_789A;
elc_error_logging u_dut (.clk, .rst, .csr_valid, .csr_write, .csr_addr,
	.csr_wdata, .csr_rdata, .csr_ready, .scan_en, .scan_in, .scan_out,
	.xb_rsp_valid, .xb_rsp_src, .xb_rsp_to_io, .xb_rsp_no_dummy,
	.short_response_packet_flag, .xb_rsp_ttype, .transaction_tag,
	.xb_rsp_chip, .xb_rsp_board, .xb_rsp_code, .xb_rsp_other, .tmo_valid,
	.tmo_addr, .msg_err_valid, .msg_err_code, .pkt_in_valid, .pkt_in_data,
	.pkt_in_par, .pkt_out_valid, .pkt_out_data, .pkt_out_par, .mem_rd_valid,
	.mem_rd_data, .mem_rd_addr, .mem_sbe, .mem_sbe_bit, .mem_mbe, .mem_is_tag,
	.mem_rsp_valid, .mem_rsp_data, .mem_rsp_par_err, .mem_sbe_intr,
	.mem_hard_err, .proc_directed_err, .proc_dummy_rsp,
	.high_priority_machine_check, .io_err_valid, .io_err_data, .msg_intr,
	.opq_wr, .opq_code, .err_ignore);
elc_xb_model u_xb (.clk, .xb_rsp_valid, .xb_rsp_src, .xb_rsp_to_io,
	.xb_rsp_no_dummy, .short_response_packet_flag, .xb_rsp_ttype,
	.transaction_tag, .xb_rsp_chip, .xb_rsp_board, .xb_rsp_code,
	.xb_rsp_other);
always #20 clk = ~clk;
// ----------------------------------------
// Tasks
// ----------------------------------------
task automatic finish_test;
	if (miscompares == 0 && checked > 0) $display("Result: passed");
	else $display("Result: failed");
	$finish;
endtask
task automatic tick(input int n);
	repeat (n) @(posedge clk);
	#1;
endtask
// Idle cycle after each access so valid never toggles twice in one step
task automatic csr(input logic w, input logic [7:0] a, input logic [63:0] d);
	{csr_valid, csr_write, csr_addr, csr_wdata} = {1'b1, w, a, d};
	tick(1);
	rdv = csr_rdata;
	csr_valid = 1'b0;
	tick(1);
endtask
task automatic rd(input logic [7:0] a, input logic [63:0] e);
	csr(1'b0, a, 64'h0);
	`CHK(rdv, e)
endtask
task automatic msg(input logic [7:0] c);
	{msg_err_valid, msg_err_code} = {1'b1, c};
	tick(1);
	msg_err_valid = 1'b0;
	tick(2);
endtask
task automatic mem(input logic [63:0] d, input logic sb, mb, tg, cd,
		input logic [63:0] ed, input logic [1:0] ep);
	{mem_rd_valid, mem_rd_data} = {1'b1, d};
	{mem_sbe, mem_mbe, mem_is_tag} = {sb, mb, tg};
	tick(1);
	`CHK({mem_rsp_valid, mem_rsp_par_err}, ep)
	if (cd) `CHK(mem_rsp_data, ed)
	mem_rd_valid = 1'b0;
	tick(2);
endtask
always @(posedge clk) begin
	cycles++;
	if (cycles == 3000) begin
		miscompares++;
		finish_test;
	end
end
// ----------------------------------------
// Sequence
// ----------------------------------------
initial begin
	tick(3);
	rst = 1'b0;
	rd(OFS_CAUSE, 64'h0);
	rd(OFS_INFO, 64'h0);
	rd(8'h38, 64'h0);
	csr(1'b1, OFS_CFG, 64'h6C10);
	rd(OFS_CFG, 64'h6C10);
	`CHK(err_ignore, 8'h1B)
	msg(8'h5A);
	`CHK(opq_code, 8'h5A)
	rd(OFS_INFO, 64'h1D);
	rd(OFS_CAUSE, 64'h80);
	{tmo_valid, tmo_addr} = {1'b1, TADR};
	tick(1);
	tmo_valid = 1'b0;
	tick(2);
	rd(OFS_INFO, 64'h81A);
	rd(OFS_ADDR, {24'h0, TADR});
	rd(OFS_SHORTRD, {24'h0, TADR});
	msg(8'h33);
	rd(OFS_INFO, 64'hC1A);
	rd(OFS_ADDR, {24'h0, TADR});
	csr(1'b1, OFS_CAUSE, 64'h80);
	rd(OFS_CAUSE, 64'h40);
	// Bad parity then good parity, back to back
	{pkt_in_valid, pkt_in_data, pkt_in_par} = {1'b1, 64'h1, 1'b0};
	tick(1);
	{pkt_in_data, pkt_in_par} = {64'h3, 1'b0};
	tick(1);
	pkt_in_valid = 1'b0;
	tick(3);
	csr(1'b0, OFS_CAUSE, 64'h0);
	`CHK(rdv[1:0], 2'h3)
	rd(OFS_INFO, 64'hC1A);
	mem(64'h0F, 1'b1, 1'b0, 1'b0, 1'b1, 64'h1F, 2'h2);
	mem(64'hAA, 1'b0, 1'b1, 1'b0, 1'b1, 64'hAA, 2'h3);
	mem(64'h55, 1'b0, 1'b1, 1'b1, 1'b0, 64'h0, 2'h0);
	csr(1'b0, OFS_CAUSE, 64'h0);
	`CHK(rdv[4:2], 3'h7)
	csr(1'b1, OFS_CTRL, 64'h1);
	u_xb.send(4'h1, 1'b0, 1'b0, FLD, 32'h0);
	rd(OFS_RSPLOG, {28'h0, 4'h1, 1'b0, FLD, 7'h0});
	rd(OFS_CTRL, 64'h5);
	csr(1'b0, OFS_INFO, 64'h0);
	`CHK(rdv[1:0], SEV_HARD)
	`CHK(rdv[INFO_O_BIT], 1'b1)
	csr(1'b0, OFS_CAUSE, 64'h0);
	`CHK(rdv, 64'h7F)
	msg(8'h01);
	rd(OFS_CAUSE, 64'h7F);
	csr(1'b1, OFS_CFG, 64'h0);
	rd(OFS_CFG, 64'h6C10);
	u_xb.send(4'h4, 1'b1, 1'b0, 24'h0, 32'hDEADBEEF);
	`CHK(io_err_data, {28'h0, 4'h4, 32'hDEADBEEF})
	rst = 1'b1;
	tick(3);
	rst = 1'b0;
	rd(OFS_CAUSE, 64'h0);
	{scan_en, scan_in} = 2'h3;
	tick(60);
	scan_en = 1'b0;
	rd(OFS_CAUSE, 64'hFF);
	rd(OFS_ADDR, 64'hFF_FFFF_FFFF);
	`CHK(scan_out, 1'b1)
	finish_test;
end
endmodule
`default_nettype wire

//--- logic/elc_ecc_report.sv
// Memory read error reporting: fixes single-bit errors, flags multibit.
// Assumes the ECC decoder upstream supplies the flags and the bad bit.
`timescale 1ns/1ps
`default_nettype none
module elc_ecc_report #(
	parameter int W = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic rd_valid,
	input wire logic [W-1:0] rd_data,
	input wire logic rd_sbe,
	input wire logic [$clog2(W)-1:0] rd_sbe_bit,
	input wire logic rd_mbe,
	input wire logic rd_is_tag,
	output logic rsp_valid,
	output logic [W-1:0] rsp_data,
	output logic rsp_par_err,
	output logic sbe_pulse,
	output logic tag_hard_pulse,
	output logic data_mbe_pulse
);
	logic [W-1:0] next_data;
	logic next_sbe;
	logic next_tag;
	logic next_dmbe;

	always_comb begin
		next_data = rd_data;
		if (rd_sbe && !rd_mbe) begin
			next_data[rd_sbe_bit] = ~rd_data[rd_sbe_bit];
		end
		next_sbe = rd_valid & rd_sbe & ~rd_mbe;
		next_tag = rd_valid & rd_mbe & rd_is_tag;
		next_dmbe = rd_valid & rd_mbe & ~rd_is_tag;
	end

	// Memory itself is left bad; software scrubs it later
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			rsp_par_err <= 1'b0;
			sbe_pulse <= 1'b0;
			tag_hard_pulse <= 1'b0;
			data_mbe_pulse <= 1'b0;
		end else begin
			rsp_valid <= rd_valid & ~rd_is_tag;
			rsp_data <= next_data;
			rsp_par_err <= next_dmbe;
			sbe_pulse <= next_sbe;
			tag_hard_pulse <= next_tag;
			data_mbe_pulse <= next_dmbe;
		end
	end
endmodule
`default_nettype wire

//--- logic/elc_error_logging.sv
// Error detection and logging CSRs with response forwarding.
// Assumes requesters on the same clock; CSR access is a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module elc_error_logging import elc_pkg::*; #(
	parameter int ADDR_W = 40,
	parameter int PKT_W = 64,
	parameter int MEM_W = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic csr_valid,
	input wire logic csr_write,
	input wire logic [CSR_AW-1:0] csr_addr,
	input wire logic [CSR_DW-1:0] csr_wdata,
	output logic [CSR_DW-1:0] csr_rdata,
	output logic csr_ready,
	input wire logic scan_en,
	input wire logic scan_in,
	output logic scan_out,
	input wire logic xb_rsp_valid,
	input wire logic [3:0] xb_rsp_src,
	input wire logic xb_rsp_to_io,
	input wire logic xb_rsp_no_dummy,
	input wire logic short_response_packet_flag,
	input wire logic [5:0] xb_rsp_ttype,
	input wire logic [5:0] transaction_tag,
	input wire logic [2:0] xb_rsp_chip,
	input wire logic [2:0] xb_rsp_board,
	input wire logic [4:0] xb_rsp_code,
	input wire logic [31:0] xb_rsp_other,
	input wire logic tmo_valid,
	input wire logic [ADDR_W-1:0] tmo_addr,
	input wire logic msg_err_valid,
	input wire logic [7:0] msg_err_code,
	input wire logic pkt_in_valid,
	input wire logic [PKT_W-1:0] pkt_in_data,
	input wire logic pkt_in_par,
	output logic pkt_out_valid,
	output logic [PKT_W-1:0] pkt_out_data,
	output logic pkt_out_par,
	input wire logic mem_rd_valid,
	input wire logic [MEM_W-1:0] mem_rd_data,
	input wire logic [ADDR_W-1:0] mem_rd_addr,
	input wire logic mem_sbe,
	input wire logic [$clog2(MEM_W)-1:0] mem_sbe_bit,
	input wire logic mem_mbe,
	input wire logic mem_is_tag,
	output logic mem_rsp_valid,
	output logic [MEM_W-1:0] mem_rsp_data,
	output logic mem_rsp_par_err,
	output logic mem_sbe_intr,
	output logic mem_hard_err,
	output logic proc_directed_err,
	output logic proc_dummy_rsp,
	output logic high_priority_machine_check,
	output logic io_err_valid,
	output logic [CSR_DW-1:0] io_err_data,
	output logic msg_intr,
	output logic opq_wr,
	output logic [7:0] opq_code,
	output logic [NCAUSE-1:0] err_ignore
);
	localparam int CHAIN_W = NCAUSE + 12 + ADDR_W;

	// --------------------------------------------------------------
	// Sub-blocks
	// --------------------------------------------------------------
	logic perr_in;
	logic perr_out;
	logic ecc_sbe;
	logic ecc_tag;
	logic ecc_dmbe;
	logic [ADDR_W-1:0] mem_addr_q;

	elc_parity_pass #(.W(PKT_W)) u_par (
		.clk(clk),
		.rst(rst),
		.in_valid(pkt_in_valid),
		.in_data(pkt_in_data),
		.in_par(pkt_in_par),
		.out_valid(pkt_out_valid),
		.out_data(pkt_out_data),
		.out_par(pkt_out_par),
		.perr_in(perr_in),
		.perr_out(perr_out)
	);

	elc_ecc_report #(.W(MEM_W)) u_ecc (
		.clk(clk),
		.rst(rst),
		.rd_valid(mem_rd_valid),
		.rd_data(mem_rd_data),
		.rd_sbe(mem_sbe),
		.rd_sbe_bit(mem_sbe_bit),
		.rd_mbe(mem_mbe),
		.rd_is_tag(mem_is_tag),
		.rsp_valid(mem_rsp_valid),
		.rsp_data(mem_rsp_data),
		.rsp_par_err(mem_rsp_par_err),
		.sbe_pulse(ecc_sbe),
		.tag_hard_pulse(ecc_tag),
		.data_mbe_pulse(ecc_dmbe)
	);

	// --------------------------------------------------------------
	// Response log word
	// --------------------------------------------------------------
	function automatic logic is_xb_in(input logic [3:0] src);
		return (src == SRC_XB0_IN) || (src == SRC_XB1_IN);
	endfunction

	function automatic logic [CSR_DW-1:0] build_log();
		logic [CSR_DW-1:0] w;
		w = '0;
		w[LOG_SRC_LSB +: 4] = xb_rsp_src;
		if (is_xb_in(xb_rsp_src)) begin
			w[LOG_SHORT_BIT] = short_response_packet_flag;
			w[LOG_TTYPE_LSB +: 6] = xb_rsp_ttype;
			w[LOG_TAG_LSB +: 6] = transaction_tag;
			w[LOG_CHIP_LSB +: 3] = xb_rsp_chip;
			w[LOG_BOARD_LSB +: 3] = xb_rsp_board;
			w[LOG_CODE_LSB +: 5] = xb_rsp_code;
		end else begin
			w[31:0] = xb_rsp_other;
		end
		return w;
	endfunction

	// --------------------------------------------------------------
	// Error state
	// --------------------------------------------------------------
	logic [NCAUSE-1:0] cause, next_cause;
	logic [2*NCAUSE-1:0] cfg, next_cfg;
	logic [1:0] info_type, next_info_type;
	logic [NUM_W-1:0] info_num, next_info_num;
	logic info_m, next_info_m;
	logic info_o, next_info_o;
	logic [ADDR_W-1:0] err_addr, next_err_addr;
	logic [CSR_DW-1:0] rsplog, next_rsplog;
	logic [ADDR_W-1:0] shortrd, next_shortrd;
	logic stop_on_hard, next_stop_on_hard;
	logic frozen, next_frozen;
	logic [NCAUSE-1:0] ev;
	logic [ADDR_W-1:0] ev_addr [NCAUSE];
	logic [1:0] best_sev;
	logic [NUM_W-1:0] best_num;
	logic [ADDR_W-1:0] best_addr;
	logic [3:0] nlog;
	logic [1:0] sev;
	logic wr_ok;
	logic [CHAIN_W-1:0] chain;

	always_comb begin
		ev = '0;
		ev[C_PAR_IN] = perr_in;
		ev[C_PAR_OUT] = perr_out;
		ev[C_MEM_SBE] = ecc_sbe;
		ev[C_MEM_TAG] = ecc_tag;
		ev[C_MEM_DATA] = ecc_dmbe;
		ev[C_XB_RSP] = xb_rsp_valid;
		ev[C_RD_TMO] = tmo_valid;
		ev[C_MSG] = msg_err_valid;
		for (int i = 0; i < NCAUSE; i++) begin
			ev_addr[i] = '0;
		end
		ev_addr[C_MEM_SBE] = mem_addr_q;
		ev_addr[C_MEM_TAG] = mem_addr_q;
		ev_addr[C_MEM_DATA] = mem_addr_q;
		ev_addr[C_RD_TMO] = tmo_addr;
	end

	// Worst enabled event this cycle; ties go to the lowest cause
	always_comb begin
		best_sev = SEV_NONE;
		best_num = '0;
		best_addr = '0;
		nlog = '0;
		sev = SEV_NONE;
		for (int i = 0; i < NCAUSE; i++) begin
			sev = cfg[2*i +: 2];
			if (ev[i] && sev != SEV_NONE) begin
				nlog = nlog + 4'h1;
				if (sev > best_sev) begin
					best_sev = sev;
					best_num = NUM_W'(i);
					best_addr = ev_addr[i];
				end
			end
		end
	end

	always_comb begin
		next_cause = cause;
		next_cfg = cfg;
		next_info_type = info_type;
		next_info_num = info_num;
		next_info_m = info_m;
		next_info_o = info_o;
		next_err_addr = err_addr;
		next_rsplog = rsplog;
		next_shortrd = shortrd;
		next_stop_on_hard = stop_on_hard;
		next_frozen = frozen;
		// Held registers still take loads, but refuse stores while frozen with stop_on_hard set; scan still owns cause, info and err_addr
		wr_ok = csr_valid & csr_write & ~(frozen & stop_on_hard);
		if (wr_ok) begin
			unique case (csr_addr)
				OFS_CAUSE: next_cause = cause & ~csr_wdata[NCAUSE-1:0];
				OFS_INFO: begin
					next_info_type = csr_wdata[INFO_TYPE_LSB +: 2];
					next_info_num = csr_wdata[INFO_NUM_LSB +: NUM_W];
					next_info_m = csr_wdata[INFO_M_BIT];
					next_info_o = csr_wdata[INFO_O_BIT];
				end
				OFS_ADDR: next_err_addr = csr_wdata[ADDR_W-1:0];
				OFS_CFG: next_cfg = csr_wdata[2*NCAUSE-1:0];
				OFS_SHORTRD: next_shortrd = csr_wdata[ADDR_W-1:0];
				OFS_CTRL: begin
					next_stop_on_hard = csr_wdata[CTRL_STOP_BIT];
					if (csr_wdata[CTRL_UNFREEZE_BIT]) begin
						next_frozen = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (!frozen) begin
			next_cause = next_cause | ev;
			if (xb_rsp_valid) begin
				next_rsplog = build_log();
			end
			if (tmo_valid) begin
				next_shortrd = tmo_addr;
			end
			if (nlog != 4'h0) begin
				if (best_sev > info_type) begin
					next_info_type = best_sev;
					next_info_num = best_num;
					next_err_addr = best_addr;
					next_info_o = (info_type != SEV_NONE);
					next_info_m = info_m | (nlog > 4'h1);
				end else begin
					next_info_m = 1'b1;
				end
				if (best_sev == SEV_HARD) begin
					next_frozen = 1'b1;
				end
			end
		end
		if (scan_en) begin
			{next_cause, next_info_o, next_info_m, next_info_num,
				next_info_type, next_err_addr} =
				{scan_in, chain[CHAIN_W-1:1]};
		end
	end

	assign chain = {cause, info_o, info_m, info_num, info_type, err_addr};

	always_ff @(posedge clk) begin
		if (rst) begin
			cause <= '0;
			cfg <= '0;
			info_type <= SEV_NONE;
			info_num <= '0;
			info_m <= 1'b0;
			info_o <= 1'b0;
			err_addr <= '0;
			rsplog <= '0;
			shortrd <= '0;
			stop_on_hard <= 1'b0;
			frozen <= 1'b0;
			mem_addr_q <= '0;
		end else begin
			cause <= next_cause;
			cfg <= next_cfg;
			info_type <= next_info_type;
			info_num <= next_info_num;
			info_m <= next_info_m;
			info_o <= next_info_o;
			err_addr <= next_err_addr;
			rsplog <= next_rsplog;
			shortrd <= next_shortrd;
			stop_on_hard <= next_stop_on_hard;
			frozen <= next_frozen;
			mem_addr_q <= mem_rd_addr;
		end
	end

	// --------------------------------------------------------------
	// CSR read port and forwarded signalling
	// --------------------------------------------------------------
	logic [CSR_DW-1:0] next_rdata;
	logic next_dir;
	logic next_dummy;
	logic next_io;
	logic pend_dummy, next_pend_dummy;

	always_comb begin
		next_rdata = '0;
		unique case (csr_addr)
			OFS_CAUSE: next_rdata[NCAUSE-1:0] = cause;
			OFS_INFO: begin
				next_rdata[INFO_TYPE_LSB +: 2] = info_type;
				next_rdata[INFO_NUM_LSB +: NUM_W] = info_num;
				next_rdata[INFO_M_BIT] = info_m;
				next_rdata[INFO_O_BIT] = info_o;
			end
			OFS_ADDR: next_rdata[ADDR_W-1:0] = err_addr;
			OFS_CFG: next_rdata[2*NCAUSE-1:0] = cfg;
			OFS_RSPLOG: next_rdata = rsplog;
			OFS_SHORTRD: next_rdata[ADDR_W-1:0] = shortrd;
			OFS_CTRL: begin
				next_rdata[CTRL_STOP_BIT] = stop_on_hard;
				next_rdata[CTRL_FROZEN_BIT] = frozen;
			end
			default: ;
		endcase
		// Forwarding happens even when logging is frozen
		next_dir = xb_rsp_valid & ~xb_rsp_to_io;
		next_pend_dummy = next_dir & ~xb_rsp_no_dummy;
		next_dummy = pend_dummy;
		next_io = xb_rsp_valid & xb_rsp_to_io;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			csr_rdata <= '0;
			csr_ready <= 1'b0;
			scan_out <= 1'b0;
			pend_dummy <= 1'b0;
			proc_directed_err <= 1'b0;
			proc_dummy_rsp <= 1'b0;
			high_priority_machine_check <= 1'b0;
			io_err_valid <= 1'b0;
			io_err_data <= '0;
			msg_intr <= 1'b0;
			opq_wr <= 1'b0;
			opq_code <= '0;
			mem_sbe_intr <= 1'b0;
			mem_hard_err <= 1'b0;
			err_ignore <= '0;
		end else begin
			csr_rdata <= csr_valid ? next_rdata : '0;
			csr_ready <= csr_valid;
			scan_out <= chain[0];
			pend_dummy <= next_pend_dummy;
			proc_directed_err <= next_dir;
			proc_dummy_rsp <= next_dummy;
			high_priority_machine_check <= next_dir;
			io_err_valid <= next_io;
			io_err_data <= next_io ? build_log() : io_err_data;
			msg_intr <= msg_err_valid;
			opq_wr <= msg_err_valid;
			opq_code <= msg_err_valid ? msg_err_code : opq_code;
			mem_sbe_intr <= ecc_sbe;
			mem_hard_err <= ecc_tag;
			for (int i = 0; i < NCAUSE; i++) begin
				err_ignore[i] <= (cfg[2*i +: 2] == SEV_NONE);
			end
		end
	end
endmodule
`default_nettype wire

//--- logic/elc_parity_pass.sv
// Crossbar router parity path: checks parity entering and leaving a stage.
// Assumes even parity over the data and one clock with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module elc_parity_pass #(
	parameter int W = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	input wire logic in_par,
	output logic out_valid,
	output logic [W-1:0] out_data,
	output logic out_par,
	output logic perr_in,
	output logic perr_out
);
	logic next_out_valid;
	logic next_perr_in;
	logic next_perr_out;

	// Parity is never regenerated, so a bad word stays bad downstream
	always_comb begin
		next_out_valid = in_valid;
		next_perr_in = in_valid & ((^in_data) != in_par);
		next_perr_out = out_valid & ((^out_data) != out_par);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data <= '0;
			out_par <= 1'b0;
			perr_in <= 1'b0;
			perr_out <= 1'b0;
		end else begin
			out_valid <= next_out_valid;
			out_data <= in_data;
			out_par <= in_par;
			perr_in <= next_perr_in;
			perr_out <= next_perr_out;
		end
	end
endmodule
`default_nettype wire

//--- pkg/elc_pkg.sv
// Constants, field layouts and register offsets of the error logger.
// Assumes one clock domain and a synchronous active-high reset.
package elc_pkg;
	localparam int CSR_AW = 8;
	localparam int CSR_DW = 64;
	localparam logic [7:0] OFS_CAUSE = 8'h00;
	localparam logic [7:0] OFS_INFO = 8'h08;
	localparam logic [7:0] OFS_ADDR = 8'h10;
	localparam logic [7:0] OFS_CFG = 8'h18;
	localparam logic [7:0] OFS_RSPLOG = 8'h20;
	localparam logic [7:0] OFS_SHORTRD = 8'h28;
	localparam logic [7:0] OFS_CTRL = 8'h30;
	// Severity codes, ordered so that a larger code is worse
	localparam logic [1:0] SEV_NONE = 2'h0;
	localparam logic [1:0] SEV_ADV = 2'h1;
	localparam logic [1:0] SEV_SOFT = 2'h2;
	localparam logic [1:0] SEV_HARD = 2'h3;
	// Info register layout
	localparam int INFO_TYPE_LSB = 0;
	localparam int INFO_NUM_LSB = 2;
	localparam int NUM_W = 8;
	localparam int INFO_M_BIT = 10;
	localparam int INFO_O_BIT = 11;
	// Control register layout
	localparam int CTRL_STOP_BIT = 0;
	localparam int CTRL_UNFREEZE_BIT = 1;
	localparam int CTRL_FROZEN_BIT = 2;
	// Cause bits
	localparam int NCAUSE = 8;
	localparam int C_PAR_IN = 0;
	localparam int C_PAR_OUT = 1;
	localparam int C_MEM_SBE = 2;
	localparam int C_MEM_TAG = 3;
	localparam int C_MEM_DATA = 4;
	localparam int C_XB_RSP = 5;
	localparam int C_RD_TMO = 6;
	localparam int C_MSG = 7;
	// Response log: bit n of the big-endian word sits at little bit 63-n
	localparam int LOG_SRC_LSB = 32;
	localparam int LOG_SHORT_BIT = 30;
	localparam int LOG_TTYPE_LSB = 24;
	localparam int LOG_TAG_LSB = 18;
	localparam int LOG_CHIP_LSB = 15;
	localparam int LOG_BOARD_LSB = 12;
	localparam int LOG_CODE_LSB = 7;
	localparam logic [3:0] SRC_XB0_IN = 4'h0;
	localparam logic [3:0] SRC_XB1_IN = 4'h1;
	localparam logic [3:0] SRC_XB0_OUT = 4'h2;
	localparam logic [3:0] SRC_XB1_OUT = 4'h3;
	localparam logic [3:0] SRC_BUS_IN = 4'h4;
	localparam logic [3:0] SRC_CSR = 4'h5;
endpackage
